// [core/i2c_event_pkg.sv]
// Package: constants and types for the two-wire event and wait control
// What this block does
// - Event flag after bit 8/9; holds clock low
// - Flag falling releases the held clock line
// - Reserved first-byte address sets flag at bit 8
// - Later-byte arbitration loss: bit 8 or 9
// - No DMA, late wait: tx-empty or rx events
// - DMA, late wait: master bus idle at bit 8
// - First-byte arbitration loss sets flag at bit 9
// - Not-acknowledge sets flag unless stop requested
// - Receive FIFO data sets flag at bit 9
// - Variant one bus error sets flag at 9
// - Variant zero bus error sets flag, no hold
// - No DMA, tx empty sets flag at bit 9
// - No DMA, early wait: bit 9 events
// - Slave receive fills FIFO: flag at bit 9
// - DMA bit 9 events for slave and master
// - Zero write, stop or restart clears flag
// - Writing one without DMA is ignored
// - DMA master bus idle masks status interrupt
// - Mode field bits 7..5 select the mode
// - Receive and transmit interrupt request outputs
// - First-byte flag set on start, cleared later
// - Wait select zero waits at 9, one at 8
// - Master select and active encode the state
// - Event interrupt only while its enable set
package i2c_event_pkg;
	// Word indices of the registers; byte address is four times these
	localparam logic [1:0] OFS_MODE   = 2'h0;
	localparam logic [1:0] OFS_CTL    = 2'h1;
	localparam logic [1:0] OFS_STATUS = 2'h2;
	localparam logic [1:0] OFS_SERIAL = 2'h3;
	// Mode register fields
	localparam int MODE_LSB = 5;
	localparam int RIE_BIT  = 3;
	localparam int TIE_BIT  = 2;
	// Control register fields
	localparam int CTL_EVENT  = 0;
	localparam int CTL_BERR   = 1;
	localparam int CTL_IRQEN  = 2;
	localparam int CTL_WAIT_POINT_SELECT   = 3;
	localparam int CTL_ACTRS  = 4;
	localparam int CTL_MSEL   = 5;
	localparam int CTL_VARIANT = 6;
	localparam int CTL_ENABLE = 7;
	// Bus status fields
	localparam int ST_FIRST = 7;
	localparam int ST_RSVD  = 5;
	localparam int ST_DIR   = 4;
	localparam int ST_ARB   = 3;
	// Serial status fields
	localparam int SER_DMA    = 0;
	localparam int SER_FIFOEN = 1;
	localparam int SER_IDLE   = 4;
	localparam int SER_TXE    = 5;
	localparam int SER_RXF    = 6;
	localparam int SER_ORE    = 7;
	// Reset value and bit positions
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_BIT       = 4'h9;
	// Operation modes
	typedef enum logic [2:0] {
		MODE_ASYNC  = 3'b000,
		MODE_MULTI  = 3'b001,
		MODE_SYNC   = 3'b010,
		MODE_LIN    = 3'b011,
		MODE_TWIRE  = 3'b100
	} op_mode_t;
	// Status of the rest of the serial unit, same clock
	typedef struct packed {
		logic txEmpty;
		logic txBusIdle;
		logic rxFull;
		logic overrun;
		logic rxFifoHasData;
		logic rxFifoFull;
		logic rsvdAddr;
		logic arbLost;
		logic nackRcvd;
		logic busErrDet;
		logic activeFlag;
		logic directionFlag;
	} unit_status_t;
	// Conditions seen on the bus lines
	typedef struct packed {
		logic start;
		logic stop;
		logic sclRise;
		logic sclFall;
	} line_event_t;
endpackage : i2c_event_pkg

// [core/line_watch.sv]
// Synchroniser and start/stop detector for the bus lines
`timescale 1ns/1ns
module line_watch
(
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        sclIn,
	input  wire logic                        sdaIn,
	output i2c_event_pkg::line_event_t       lineEv
);
	import i2c_event_pkg::*;
	logic sclMeta, sclSync, sclLast;        // Clock line stages
	logic sdaMeta, sdaSync, sdaLast;        // Data line stages

	////////////////////////////////////////////////////////////////
	// Two flops before use; the third stage only feeds edge finding
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// Idle bus floats high
			{sclMeta, sclSync, sclLast} <= 3'h7;
			{sdaMeta, sdaSync, sdaLast} <= 3'h7;
		end
		else
		begin
			{sclMeta, sclSync, sclLast} <= {sclIn, sclMeta, sclSync};
			{sdaMeta, sdaSync, sdaLast} <= {sdaIn, sdaMeta, sdaSync};
		end
	end

	////////////////////////////////////////////////////////////////
	// Start is data falling with clock high, stop is data rising
	always_comb
	begin
		lineEv.start   = sclSync && sclLast && sdaLast && !sdaSync;
		lineEv.stop    = sclSync && sclLast && !sdaLast && sdaSync;
		lineEv.sclRise = sclSync && !sclLast;
		lineEv.sclFall = !sclSync && sclLast;
	end
endmodule : line_watch

// [core/bit_counter.sv]
// Bit position counter giving the eighth and ninth clock falls
`timescale 1ns/1ns
module bit_counter
(
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        enable,
	input  i2c_event_pkg::line_event_t       lineEv,
	output logic                             at8,
	output logic                             at9
);
	import i2c_event_pkg::*;
	logic [3:0] bitCount;                   // Clock highs seen in byte

	////////////////////////////////////////////////////////////////
	// Count rising clock edges; report the falls that end bit 8 and 9
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bitCount <= 4'h0;
			at8      <= 1'b0;
			at9      <= 1'b0;
		end
		else
		begin
			at8 <= enable && lineEv.sclFall && bitCount == BITS_PER_BYTE;
			at9 <= enable && lineEv.sclFall && bitCount == ACK_BIT;
			if (!enable || lineEv.start || lineEv.stop)
				bitCount <= 4'h0;     // Restart framing on conditions
			else if (lineEv.sclFall && bitCount == ACK_BIT)
				bitCount <= 4'h0;     // Acknowledge done, next byte
			else if (lineEv.sclRise)
				bitCount <= bitCount + 4'h1;
		end
	end
endmodule : bit_counter

// [core/i2c_event_wait.sv]
// Event flag, clock wait and mode status logic of the two-wire mode
`timescale 1ns/1ns
module i2c_event_wait
(
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic [1:0]                  address,
	input  wire logic                        read,
	input  wire logic                        write,
	input  wire logic [31:0]                 writedata,
	output logic      [31:0]                 readdata,
	output logic                             waitrequest,
	input  i2c_event_pkg::unit_status_t      unitSt,
	input  wire logic                        sclIn,
	input  wire logic                        sdaIn,
	output logic                             sclOut,
	output logic                             sclOe,
	output logic                             statusIrq,
	output logic                             rxIrq,
	output logic                             txIrq,
	output logic                             restartPulse
);
	import i2c_event_pkg::*;

	////////////////////////////////////////////////////////////////
	// Declarations
	line_event_t lineEv;                    // Conditions on the lines
	logic        at8, at9;                  // Bit position pulses
	op_mode_t    opMode;                    // Selected operation mode
	logic        rxIrqEnable, txIrqEnable;  // Mode register enables
	logic        xferEvent;                 // Transfer event flag
	logic        errNoHold;                 // Flag raised by plain error
	logic        busErrorFlag;              // Sticky bus error
	logic        eventIrqEnable;            // Gates the status interrupt
	logic        waitPointSelect;           // 1 waits at bit 8
	logic        masterSelect;              // Master requested
	logic        errVariant;                // Error handling variant
	logic        ifEnable;                  // Interface enable
	logic        dmaEnable;                 // DMA mode
	logic        rxFifoEnable;              // Receive FIFO in use
	logic        firstByte;                 // First byte after a start
	logic        stopRequested;             // Master select cleared
	logic        wrTake;                    // Write accepted this edge
	logic        ctlWrite;                  // Write to control register
	logic [7:0]  wbyte;                     // Low byte of write data
	logic [7:0]  next_readdata;             // Read mux
	logic        masterOp, slaveTx, slaveRx;
	logic        laterByte, rsvdFirst;
	logic        set8, set9, setEvent;      // Event sources
	logic        clearEvent;                // Software clear
	logic        idleMask;                  // Status interrupt mask term

	////////////////////////////////////////////////////////////////
	// Line conditions and bit framing
	line_watch u_line_watch
	(
		.clk    (clk),
		.rst_b  (rst_b),
		.sclIn  (sclIn),
		.sdaIn  (sdaIn),
		.lineEv (lineEv)
	);

	bit_counter u_bit_counter
	(
		.clk    (clk),
		.rst_b  (rst_b),
		.enable (ifEnable),
		.lineEv (lineEv),
		.at8    (at8),
		.at9    (at9)
	);

	////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then data and write effect
	assign wrTake   = write && !waitrequest;
	assign wbyte    = writedata[7:0];
	assign ctlWrite = wrTake && address == OFS_CTL;

	// Read mux; unused upper bits and reserved bits read zero
	always_comb
	begin
		next_readdata = 8'h00;
		case (address)
			OFS_MODE:
			begin
				next_readdata[MODE_LSB +: 3] = opMode;
				next_readdata[RIE_BIT] = rxIrqEnable;
				next_readdata[TIE_BIT] = txIrqEnable;
			end
			OFS_CTL:
			begin
				next_readdata[CTL_EVENT]   = xferEvent;
				next_readdata[CTL_BERR]    = busErrorFlag;
				next_readdata[CTL_IRQEN]   = eventIrqEnable;
				next_readdata[CTL_WAIT_POINT_SELECT]    = waitPointSelect;
				next_readdata[CTL_ACTRS]   = unitSt.activeFlag;
				// Master select reads one while a master transfer runs
				next_readdata[CTL_MSEL]    = masterSelect ||
					(stopRequested && unitSt.activeFlag);
				next_readdata[CTL_VARIANT] = errVariant;
				next_readdata[CTL_ENABLE]  = ifEnable;
			end
			OFS_STATUS:
			begin
				next_readdata[ST_FIRST] = firstByte;
				next_readdata[ST_RSVD]  = unitSt.rsvdAddr;
				next_readdata[ST_DIR]   = unitSt.directionFlag;
				next_readdata[ST_ARB]   = unitSt.arbLost;
			end
			OFS_SERIAL:
			begin
				next_readdata[SER_DMA]    = dmaEnable;
				next_readdata[SER_FIFOEN] = rxFifoEnable;
				next_readdata[SER_IDLE]   = unitSt.txBusIdle;
				next_readdata[SER_TXE]    = unitSt.txEmpty;
				next_readdata[SER_RXF]    = unitSt.rxFull;
				next_readdata[SER_ORE]    = unitSt.overrun;
			end
			default: next_readdata = 8'h00;
		endcase
	end

	// Handshake: waitrequest drops for one cycle per request
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end
		else if (waitrequest && (read || write))
		begin
			waitrequest <= 1'b0;
			readdata    <= {24'h00_0000, next_readdata};
		end
		else
			waitrequest <= 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// Mode register; reserved bits are not stored
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			opMode      <= op_mode_t'(MODE_RESET);
			rxIrqEnable <= 1'b0;
			txIrqEnable <= 1'b0;
		end
		else if (wrTake && address == OFS_MODE)
		begin
			opMode      <= op_mode_t'(wbyte[MODE_LSB +: 3]);
			rxIrqEnable <= wbyte[RIE_BIT];
			txIrqEnable <= wbyte[TIE_BIT];
		end
	end

	// Control and serial status bits that software owns
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			eventIrqEnable  <= 1'b0;
			waitPointSelect <= 1'b0;
			masterSelect    <= 1'b0;
			errVariant      <= 1'b0;
			ifEnable        <= 1'b0;
			dmaEnable       <= 1'b0;
			rxFifoEnable    <= 1'b0;
		end
		else
		begin
			if (ctlWrite)
			begin
				eventIrqEnable  <= wbyte[CTL_IRQEN];
				waitPointSelect <= wbyte[CTL_WAIT_POINT_SELECT];
				masterSelect    <= wbyte[CTL_MSEL];
				errVariant      <= wbyte[CTL_VARIANT];
				ifEnable        <= wbyte[CTL_ENABLE];
			end
			if (wrTake && address == OFS_SERIAL)
			begin
				dmaEnable    <= wbyte[SER_DMA];
				rxFifoEnable <= wbyte[SER_FIFOEN];
			end
		end
	end

	// Restart request pulse and stop-request memory for master mode
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			restartPulse  <= 1'b0;
			stopRequested <= 1'b0;
		end
		else
		begin
			restartPulse <= ctlWrite && wbyte[CTL_ACTRS] && masterOp;
			// Clearing master select mid-transfer asks for a stop
			if (ctlWrite && !wbyte[CTL_MSEL] && masterOp)
				stopRequested <= 1'b1;
			else if (lineEv.start || !unitSt.activeFlag)
				stopRequested <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Event sources
	assign masterOp  = masterSelect && unitSt.activeFlag;
	assign slaveTx   = !masterSelect && unitSt.activeFlag &&
		unitSt.directionFlag;
	assign slaveRx   = !masterSelect && unitSt.activeFlag &&
		!unitSt.directionFlag;
	assign laterByte = !firstByte;
	assign rsvdFirst = unitSt.rsvdAddr;

	// Eighth clock fall; the wait point decides for ordinary bytes
	always_comb
	begin
		set8 = firstByte && rsvdFirst;
		set8 = set8 || (waitPointSelect && laterByte &&
			unitSt.arbLost);
		set8 = set8 || (!dmaEnable && waitPointSelect &&
			(((masterOp || slaveTx) && unitSt.txEmpty && laterByte) ||
			(slaveRx && !rxFifoEnable)));
		set8 = set8 || (dmaEnable && waitPointSelect && masterOp &&
			unitSt.txBusIdle && laterByte);
	end

	// Ninth clock fall, after the acknowledge
	always_comb
	begin
		set9 = firstByte && unitSt.arbLost;
		set9 = set9 || (unitSt.nackRcvd && !stopRequested);
		set9 = set9 || (rxFifoEnable && !rsvdFirst &&
			unitSt.rxFifoHasData && !unitSt.directionFlag &&
			unitSt.activeFlag);
		set9 = set9 || (errVariant && busErrorFlag);
		set9 = set9 || (!waitPointSelect && laterByte &&
			unitSt.arbLost);
		set9 = set9 || (!dmaEnable && !rsvdFirst && unitSt.txEmpty &&
			unitSt.activeFlag && (unitSt.directionFlag ||
			!rxFifoEnable));
		set9 = set9 || (!dmaEnable && !waitPointSelect &&
			((((masterOp || slaveTx) && unitSt.txEmpty) && laterByte) ||
			(slaveRx && !rxFifoEnable && !rsvdFirst)));
		set9 = set9 || (!dmaEnable && rxFifoEnable && slaveRx &&
			unitSt.rxFifoFull);
		set9 = set9 || (dmaEnable && ((slaveTx && unitSt.txEmpty) ||
			(slaveRx && !rxFifoEnable && unitSt.txEmpty) ||
			(masterOp && !waitPointSelect && unitSt.txBusIdle &&
			laterByte)));
	end

	// Plain bus error raises the flag at once and never waits the bus
	assign setEvent = ifEnable && ((at8 && set8) || (at9 && set9) ||
		(unitSt.busErrDet && !errVariant) ||
		(ctlWrite && wbyte[CTL_EVENT] && dmaEnable && !xferEvent));
	// Zero write, stop or restart request while active clears it
	assign clearEvent = ctlWrite && (!wbyte[CTL_EVENT] ||
		(xferEvent && unitSt.activeFlag &&
		(!wbyte[CTL_MSEL] || wbyte[CTL_ACTRS])));

	////////////////////////////////////////////////////////////////
	// Event flag: a set in the clearing cycle wins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			xferEvent <= 1'b0;
			errNoHold <= 1'b0;
		end
		else
		begin
			if (setEvent)
				xferEvent <= 1'b1;
			else if (clearEvent)
				xferEvent <= 1'b0;
			// Writing one without DMA falls through and changes nothing
			if (ifEnable && unitSt.busErrDet && !errVariant)
				errNoHold <= 1'b1;
			else if (!xferEvent)
				errNoHold <= 1'b0;
		end
	end

	// Bus error flag, cleared by a zero event-flag write or on disable
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			busErrorFlag <= 1'b0;
		else if (ifEnable && unitSt.busErrDet)
			busErrorFlag <= 1'b1;
		else if (!ifEnable || (ctlWrite && !wbyte[CTL_EVENT]))
			busErrorFlag <= 1'b0;
	end

	// First byte after a start or repeated start
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			firstByte <= 1'b0;
		else if (ifEnable && lineEv.start)
			firstByte <= 1'b1;
		else if (!ifEnable || lineEv.stop || at9 ||
			(unitSt.busErrDet && !errVariant))
			firstByte <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Clock wait and interrupt outputs, all registered
	assign idleMask = dmaEnable && masterOp && unitSt.txBusIdle &&
		laterByte;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclOut    <= 1'b0;
			sclOe     <= 1'b0;
			statusIrq <= 1'b0;
			rxIrq     <= 1'b0;
			txIrq     <= 1'b0;
		end
		else
		begin
			// Open drain: drive low while waiting, else let pull-up win
			sclOut    <= 1'b0;
			sclOe     <= xferEvent && !errNoHold;
			statusIrq <= xferEvent && eventIrqEnable &&
				!idleMask;
			rxIrq     <= rxIrqEnable &&
				(unitSt.rxFull || unitSt.overrun);
			txIrq     <= txIrqEnable && unitSt.txEmpty;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence clearWrite;
		ctlWrite && !wbyte[CTL_EVENT] && !setEvent;
	endsequence
	sequence flagDrops;
		xferEvent ##1 !xferEvent;
	endsequence

	a_hold_scl: assert property (xferEvent && !errNoHold |=> sclOe)
		else $error("clock not held while event flag set");
	a_release_scl: assert property (flagDrops |=> !sclOe)
		else $error("clock still held after flag cleared");
	a_rsvd_at8: assert property (ifEnable && at8 && firstByte &&
		rsvdFirst |=> xferEvent)
		else $error("reserved address did not raise flag");
	a_arb_first: assert property (ifEnable && at9 && firstByte &&
		unitSt.arbLost |=> xferEvent)
		else $error("first byte arbitration loss missed");
	a_err_nohold: assert property (ifEnable && unitSt.busErrDet &&
		!errVariant |=> xferEvent && errNoHold ##1 !sclOe)
		else $error("plain bus error held the clock");
	a_clear_write: assert property (clearWrite |=> !xferEvent)
		else $error("zero write did not clear flag");
	a_set_ignored: assert property (ctlWrite && wbyte[CTL_EVENT] &&
		!dmaEnable && !xferEvent && !setEvent |=> !xferEvent)
		else $error("one write set flag without DMA");
	a_irq_gate: assert property (statusIrq |->
		$past(xferEvent && eventIrqEnable && !idleMask))
		else $error("status interrupt without enabled flag");
	a_rx_irq: assert property (rxIrqEnable && unitSt.overrun |=> rxIrq)
		else $error("overrun gave no receive interrupt");
	a_first_byte: assert property (ifEnable && lineEv.start
		|=> firstByte)
		else $error("first byte flag not set on start");
	a_first_clear: assert property (firstByte && at9 &&
		!lineEv.start |=> !firstByte)
		else $error("first byte flag not cleared at byte end");
endmodule : i2c_event_wait

// [tb/bus_peer.sv]
// Peer master on the two-wire bus: start, one byte, then stop
`timescale 1ns/1ns
module bus_peer
(
	input  wire logic clk,
	input  wire logic sclOe,
	input  wire logic frameGo,
	output logic      sclIn,
	output logic      sdaIn
);
	logic sclDrv; // Peer clock drive, high = released
	int   i;      // Bit counter within the frame
	// Wired-AND with pull-up; the device can only pull low
	assign sclIn = sclDrv & ~sclOe;
	initial
	begin
		sclDrv = 1'b1;
		sdaIn  = 1'b1;
	end
	// Clock stands still between frames; stretching honoured on rises
	// Clock and start/final stop data move on falling system edges; bit data and the stop's low go on rising ones
	always @(posedge frameGo)
	begin
		@(negedge clk);
		sdaIn = 1'b0;
		#80 sclDrv = 1'b0;
		for (i = 0; i < 9; i++)
		begin
			// Long low phase outlasts the device's few-cycle stretch delay
			#50 sdaIn = (i < 4) ? 1'b0 : 1'b1;
			#50 sclDrv = 1'b1;
			wait (sclIn);
			@(negedge clk);
			#40 sclDrv = 1'b0;
		end
		// Stop: data low then high while clock is high
		#50 sdaIn = 1'b0;
		#50 sclDrv = 1'b1;
		wait (sclIn);
		@(negedge clk);
		#40 sdaIn = 1'b1;
	end
endmodule : bus_peer

// [tb/testbench.sv]
// Self-checking bench for the event flag and clock-wait block
`timescale 1ns/1ns
module testbench;
	import i2c_event_pkg::*;
	logic         clk, rst_b, read, write, frameGo;
	logic [1:0]   address;
	logic [31:0]  writedata, readdata, q;
	logic         waitrequest, sclIn, sdaIn, sclOut, sclOe;
	logic         statusIrq, rxIrq, txIrq, restartPulse;
	unit_status_t unitSt;
	int           miscompares, compares, cycles, n;
	////////////////////////////////////////////////////////////////////
	i2c_event_wait DUT (.clk(clk), .rst_b(rst_b), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .unitSt(unitSt),
		.sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe),
		.statusIrq(statusIrq), .rxIrq(rxIrq), .txIrq(txIrq),
		.restartPulse(restartPulse));
	bus_peer peer (.clk(clk), .sclOe(sclOe), .frameGo(frameGo),
		.sclIn(sclIn), .sdaIn(sdaIn));
	// 50 MHz clock
	always #10 clk = ~clk;
	// Hang guard, well above the expected run
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////
	// Avalon access; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [1:0] a,
		input logic [7:0] d);
		int k;
		k = 0;
		address   <= a;
		writedata <= {24'h00_0000, d};
		write     <= w;
		read      <= ~w;
		@(posedge clk);
		while (waitrequest !== 1'b0 && k < 50)
		begin
			@(posedge clk);
			k++;
		end
		// Read data taken at the same edge that sees waitrequest low
		q = readdata;
		if (k == 50)
			miscompares++;
		write <= 1'b0;
		read  <= 1'b0;
		// One idle edge so the next call never reassigns in this step
		@(posedge clk);
	endtask : bus
	// Compare one value and count it
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
			miscompares++;
		end
	endtask : chk
	// Wait for the wait output to reach a level, bounded
	task automatic waitOe(input logic v);
		n = 0;
		while (sclOe !== v && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
	endtask : waitOe
	// Verdict, reached from the end of the tests or the hang guard
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		clk = 0; rst_b = 0; read = 0; write = 0; frameGo = 0;
		address = 2'h0; writedata = 32'h0000_0000; unitSt = '0;
		miscompares = 0; compares = 0; cycles = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		// Mode register: reset, reserved bits, every mode code
		bus(0, OFS_MODE, 8'h00);
		chk("mode reset", 32'h0000_0000, q);
		bus(1, OFS_MODE, 8'hFF);
		bus(0, OFS_MODE, 8'h00);
		chk("mode rsvd", 32'h0000_00EC, q);
		for (int c = 0; c < 5; c++)
		begin
			bus(1, OFS_MODE, {c[2:0], 5'h00});
			bus(0, OFS_MODE, 8'h00);
			chk("mode code", {24'h0, c[2:0], 5'h00}, q);
		end
		$display("test mode done");
		// Receive and transmit requests
		unitSt.rxFull <= 1'b1;
		bus(1, OFS_MODE, 8'h88);
		repeat (2) @(posedge clk);
		chk("rxIrq full", 1, rxIrq);
		chk("txIrq off", 0, txIrq);
		unitSt.rxFull  <= 1'b0;
		unitSt.overrun <= 1'b1;
		unitSt.txEmpty <= 1'b1;
		bus(1, OFS_MODE, 8'h84);
		repeat (2) @(posedge clk);
		chk("rxIrq masked", 0, rxIrq);
		chk("txIrq on", 1, txIrq);
		bus(1, OFS_MODE, 8'h88);
		repeat (2) @(posedge clk);
		chk("rxIrq overrun", 1, rxIrq);
		unitSt <= '0;
		$display("test interrupts done");
		// Setting the flag by software is ignored without DMA
		bus(1, OFS_CTL, 8'h8D);
		bus(0, OFS_CTL, 8'h00);
		chk("flag set ignored", 0, q[CTL_EVENT]);
		$display("test flag write done");
		// Reserved first byte: event at bit 8, clock held, then released
		unitSt.rsvdAddr <= 1'b1;
		frameGo <= 1'b1;
		waitOe(1'b1);
		chk("hold", 1, sclOe);
		repeat (20) @(posedge clk);
		chk("line held", 0, sclIn);
		chk("statusIrq", 1, statusIrq);
		bus(0, OFS_CTL, 8'h00);
		chk("flag read", 1, q[CTL_EVENT]);
		bus(0, OFS_STATUS, 8'h00);
		chk("first byte", 1, q[ST_FIRST]);
		bus(1, OFS_CTL, 8'h88);
		waitOe(1'b0);
		chk("release", 0, sclOe);
		@(posedge clk);
		chk("irq cleared", 0, statusIrq);
		unitSt.rsvdAddr <= 1'b0;
		repeat (60) @(posedge clk);
		bus(0, OFS_STATUS, 8'h00);
		chk("first after stop", 0, q[ST_FIRST]);
		$display("test event done");
		// DMA restart steps, idle mask, then a plain bus error
		unitSt.activeFlag <= 1'b1;
		unitSt.txBusIdle  <= 1'b1;
		bus(1, OFS_SERIAL, 8'h01);
		bus(1, OFS_CTL, 8'hA5);
		bus(0, OFS_CTL, 8'h00);
		chk("ctl dma set", 32'h0000_00B5, q);
		chk("dma hold", 1, sclOe);
		chk("idle mask", 0, statusIrq);
		chk("scl level", 0, sclOut);
		bus(1, OFS_CTL, 8'hB5);
		chk("restart", 1, restartPulse);
		@(posedge clk);
		chk("restart pulse", 0, restartPulse);
		bus(0, OFS_CTL, 8'h00);
		chk("restart clears", 0, q[CTL_EVENT]);
		unitSt.busErrDet <= 1'b1;
		@(posedge clk);
		unitSt.busErrDet <= 1'b0;
		repeat (4) @(posedge clk);
		chk("error no hold", 0, sclOe);
		bus(0, OFS_CTL, 8'h00);
		chk("error flags", 3, q[1:0]);
		bus(1, OFS_CTL, 8'h80);
		bus(0, OFS_CTL, 8'h00);
		chk("error cleared", 0, q[1:0]);
		$display("test dma and error done");
		finish_test();
	end
endmodule : testbench
